// [mhi_pkg.sv]
package mhi_pkg;
   localparam int CLK_PERIOD_NS = 50;
   // Quadrature step period sets the highest count rate on each axis.
   localparam int STEP_TIME_NS = 10000;
   localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_TIME_US = 100000;
   localparam int IDLE_CYCLES = (IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDOG_TIME_US = 1700;
   localparam int WDOG_CYCLES = (WDOG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELTA_W = 8;
   localparam int ACC_W = 12;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int DIR_BIT = 7;
   localparam logic [1:0] QUAD_RESET = 2'h0;
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [1:0] {
      MHI_ADDR = 2'b00,
      MHI_WRITE = 2'b01,
      MHI_READ = 2'b10
   } mhi_port_t;

   // Gray order 00, 01, 11, 10; one phase changes per step.
   function automatic logic [1:0] mhi_gray(input logic [1:0] idx);
      mhi_gray = {idx[1], idx[1] ^ idx[0]};
   endfunction
endpackage

// [mhi_axis_if.sv]
`timescale 1ns/1ns
interface mhi_axis_if;
   logic load;
   logic signed [mhi_pkg::DELTA_W-1:0] delta;
   logic step_en;
   logic halt;
   logic phase_a;
   logic phase_b;
   logic idle;
   modport ctrl (output load, delta, step_en, halt, input phase_a, phase_b, idle);
   modport axis (input load, delta, step_en, halt, output phase_a, phase_b, idle);
endinterface

// [mhi_quad_axis.sv]
`timescale 1ns/1ns
module mhi_quad_axis (
   input wire logic clock,
   input wire logic rst_n,
   mhi_axis_if.axis ax
);
   logic signed [mhi_pkg::ACC_W-1:0] acc;
   logic [1:0] quad;
   logic signed [mhi_pkg::ACC_W-1:0] add_val;
   logic do_step;
   logic fwd;
   logic signed [mhi_pkg::ACC_W-1:0] step_val;
   logic signed [mhi_pkg::ACC_W-1:0] next_acc;
   logic [1:0] next_quad;
   logic [1:0] gray_q;

   // A positive remainder steps forward, a negative one backward.
   assign add_val = ax.load ? mhi_pkg::ACC_W'(ax.delta) : '0;
   assign fwd = ~acc[mhi_pkg::ACC_W-1];
   assign do_step = ax.step_en & ~ax.halt & (acc != '0);
   assign step_val = do_step ? (fwd ? mhi_pkg::ACC_W'(1) : -mhi_pkg::ACC_W'(1)) : '0;
   assign next_acc = acc + add_val - step_val;
   assign next_quad = do_step ? (fwd ? quad + 2'h1 : quad - 2'h1) : quad;
   assign gray_q = mhi_pkg::mhi_gray(quad);
   assign ax.phase_a = gray_q[1];
   assign ax.phase_b = gray_q[0];
   assign ax.idle = (acc == '0);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc <= '0;
         quad <= mhi_pkg::QUAD_RESET;
      end else begin
         acc <= next_acc;
         quad <= next_quad;
      end
   end
endmodule

// [mhi_top.sv]
// How it works
// - Displacement becomes two quadrature pairs.
// - Quadrature machine starts in state zero.
// - Power-down halts machine; resumes where stopped.
// - No motion for a while enters power saving.
// - Idle axis holds its last phases.
// - Each neighbouring step is one count.
// - Data line changes only after falling edge.
// - Only host starts transactions.
// - Address byte with direction bit, then data.
// - Direction one means write.
// - Write data sampled on rising clock edges.
// - Direction zero means device returns data.
// - Host releases after address, device after data.
// - After a write the pin stays input.
// - Last read bit held until next rise.
// - Power-down aborts transaction without register write.
// - Power-down high keeps shutdown; low resumes.
// - Idle clock watchdog resets the serial port.
`timescale 1ns/1ns
module mhi_top #(
   parameter int IDLE_CYCLES = mhi_pkg::IDLE_CYCLES,
   parameter int WDOG_CYCLES = mhi_pkg::WDOG_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic power_down_in,
   input wire logic sclk_in,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe_n,
   input wire logic motion_valid,
   input wire logic signed [mhi_pkg::DELTA_W-1:0] delta_x,
   input wire logic signed [mhi_pkg::DELTA_W-1:0] delta_y,
   output logic x_phase_a,
   output logic x_phase_b,
   output logic y_phase_a,
   output logic y_phase_b,
   output logic power_save,
   output logic shutdown,
   output logic [mhi_pkg::ADDR_W-1:0] reg_addr,
   output logic [mhi_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [mhi_pkg::DATA_W-1:0] reg_rdata
);
   mhi_axis_if x_if ();
   mhi_axis_if y_if ();

   // Pin inputs pass three flops; a change counts once the last two agree.
   logic [2:0] sclk_s;
   logic [2:0] sdio_s;
   logic [2:0] pd_s;
   logic sclk_f;
   logic sdio_f;
   logic pd_f;
   logic sclk_prev;

   // A synchronised level is taken once the last two stages agree.
   function automatic logic mhi_settle(input logic [2:0] s, input logic held);
      mhi_settle = (s[1] == s[2]) ? s[2] : held;
   endfunction

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s <= 3'h7;
         sdio_s <= 3'h0;
         pd_s <= 3'h0;
         sclk_f <= 1'b1;
         sdio_f <= 1'b0;
         pd_f <= 1'b0;
         sclk_prev <= 1'b1;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk_in};
         sdio_s <= {sdio_s[1:0], sdio_in};
         pd_s <= {pd_s[1:0], power_down_in};
         sclk_f <= mhi_settle(sclk_s, sclk_f);
         sdio_f <= mhi_settle(sdio_s, sdio_f);
         pd_f <= mhi_settle(pd_s, pd_f);
         sclk_prev <= sclk_f;
      end
   end

   // Only host clock edges advance the port; power-down and the watchdog reset it.
   logic sclk_rise;
   logic sclk_fall;
   assign sclk_rise = sclk_f & ~sclk_prev;
   assign sclk_fall = ~sclk_f & sclk_prev;

   // Step rate divider shared by both axes.
   logic [$clog2(mhi_pkg::STEP_CYCLES)-1:0] step_cnt;
   logic step_tick;
   assign step_tick = (step_cnt == '0);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_cnt <= '0;
      end else if (step_tick) begin
         step_cnt <= ($clog2(mhi_pkg::STEP_CYCLES))'(mhi_pkg::STEP_CYCLES - 1);
      end else begin
         step_cnt <= step_cnt - 1'b1;
      end
   end

   // Power saving slows stepping is not modelled; it only reports the idle state.
   assign x_if.load = motion_valid;
   assign x_if.delta = delta_x;
   assign x_if.step_en = step_tick;
   assign x_if.halt = pd_f;
   assign y_if.load = motion_valid;
   assign y_if.delta = delta_y;
   assign y_if.step_en = step_tick;
   assign y_if.halt = pd_f;

   mhi_quad_axis u_x (
      .clock(clock),
      .rst_n(rst_n),
      .ax(x_if.axis)
   );

   mhi_quad_axis u_y (
      .clock(clock),
      .rst_n(rst_n),
      .ax(y_if.axis)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         x_phase_a <= 1'b0;
         x_phase_b <= 1'b0;
         y_phase_a <= 1'b0;
         y_phase_b <= 1'b0;
         shutdown <= 1'b0;
      end else begin
         x_phase_a <= x_if.phase_a;
         x_phase_b <= x_if.phase_b;
         y_phase_a <= y_if.phase_a;
         y_phase_b <= y_if.phase_b;
         shutdown <= pd_f;
      end
   end

   // No-motion timer.
   logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt;
   logic moving;
   logic idle_done;
   assign moving = (motion_valid & ((delta_x != '0) | (delta_y != '0))) | ~x_if.idle | ~y_if.idle;
   assign idle_done = (idle_cnt == ($clog2(IDLE_CYCLES+1))'(IDLE_CYCLES));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt <= '0;
         power_save <= 1'b0;
      end else if (moving) begin
         idle_cnt <= '0;
         power_save <= 1'b0;
      end else if (idle_done) begin
         power_save <= 1'b1;
      end else begin
         idle_cnt <= idle_cnt + 1'b1;
      end
   end

   // Serial port.
   mhi_pkg::mhi_port_t state;
   mhi_pkg::mhi_port_t next_state;
   logic [2:0] bit_cnt;
   logic [mhi_pkg::DATA_W-1:0] shift;
   logic rd_loaded;
   logic [$clog2(WDOG_CYCLES+1)-1:0] wdog_cnt;
   logic busy;
   logic wdog_fire;
   logic port_reset;
   logic last_bit;
   logic [mhi_pkg::DATA_W-1:0] shift_in;
   logic in_addr;
   logic in_write;
   logic in_read;
   logic addr_done;
   logic write_done;
   logic read_done;
   logic read_fall;
   logic [mhi_pkg::DATA_W-1:0] read_src;
   logic drive_bit;

   assign busy = (state != mhi_pkg::MHI_ADDR) | (bit_cnt != '0);
   assign wdog_fire = (wdog_cnt == ($clog2(WDOG_CYCLES+1))'(WDOG_CYCLES));
   // Power-down and the watchdog reset only the port, never the register file.
   assign port_reset = pd_f | wdog_fire;
   assign last_bit = (bit_cnt == mhi_pkg::LAST_BIT);
   assign shift_in = {shift[mhi_pkg::DATA_W-2:0], sdio_f};
   assign in_addr = (state == mhi_pkg::MHI_ADDR);
   assign in_write = (state == mhi_pkg::MHI_WRITE);
   assign in_read = (state == mhi_pkg::MHI_READ);
   // Port reset masks every byte end, so an aborted transaction never writes.
   assign addr_done = ~port_reset & sclk_rise & last_bit & in_addr;
   assign write_done = ~port_reset & sclk_rise & last_bit & in_write;
   assign read_done = ~port_reset & sclk_rise & last_bit & in_read;
   assign read_fall = ~port_reset & sclk_fall & in_read;
   // The first fall of the data byte takes the word from the port, later falls the shifter.
   assign read_src = rd_loaded ? shift : reg_rdata;
   assign drive_bit = read_src[mhi_pkg::DATA_W-1];

   always_comb begin
      next_state = state;
      if (sclk_rise && last_bit) begin
         case (state)
            mhi_pkg::MHI_ADDR: begin
               next_state = shift_in[mhi_pkg::DIR_BIT] ? mhi_pkg::MHI_WRITE
                                                       : mhi_pkg::MHI_READ;
            end
            mhi_pkg::MHI_WRITE: begin
               next_state = mhi_pkg::MHI_ADDR;
            end
            mhi_pkg::MHI_READ: begin
               next_state = mhi_pkg::MHI_ADDR;
            end
            default: begin
               next_state = mhi_pkg::MHI_ADDR;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wdog_cnt <= '0;
      end else if (!busy || sclk_rise || sclk_fall || port_reset) begin
         wdog_cnt <= '0;
      end else begin
         wdog_cnt <= wdog_cnt + 1'b1;
      end
   end

   // Sequencer: state and bit count advance on host clock rises; port reset clears them.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= mhi_pkg::MHI_ADDR;
         bit_cnt <= '0;
      end else if (port_reset) begin
         state <= mhi_pkg::MHI_ADDR;
         bit_cnt <= '0;
      end else if (sclk_rise) begin
         state <= next_state;
         bit_cnt <= bit_cnt + 1'b1;
      end
   end

   // Shifter: collects address and write data, and empties the read word.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shift <= '0;
      end else if (sclk_rise && !port_reset && !in_read) begin
         shift <= shift_in;
      end else if (read_fall) begin
         shift <= {read_src[mhi_pkg::DATA_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_loaded <= 1'b0;
      end else if (port_reset || read_done) begin
         rd_loaded <= 1'b0;
      end else if (read_fall) begin
         rd_loaded <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_addr <= '0;
         reg_wdata <= '0;
         reg_write <= 1'b0;
         reg_read <= 1'b0;
      end else begin
         reg_write <= write_done;
         reg_read <= addr_done & ~shift_in[mhi_pkg::DIR_BIT];
         if (addr_done) begin
            reg_addr <= shift_in[mhi_pkg::ADDR_W-1:0];
         end
         if (write_done) begin
            reg_wdata <= shift_in;
         end
      end
   end

   // Drive starts on the first fall after the address, so the host has released.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sdio_out <= 1'b0;
         sdio_oe_n <= 1'b1;
      end else if (port_reset) begin
         sdio_oe_n <= 1'b1;
      end else if (read_done || in_write) begin
         // The final bit stands until this rising edge; a write never turns the pin.
         sdio_oe_n <= 1'b1;
      end else if (read_fall) begin
         sdio_oe_n <= 1'b0;
         sdio_out <= drive_bit;
      end
   end
endmodule

// [mhi_host_model.sv]
`timescale 1ns/1ns
module mhi_host_model (
   input wire logic clock,
   input wire logic sdio_out,
   input wire logic sdio_oe_n,
   output logic sclk_in,
   output logic sdio_in
);
   logic host_oe;
   logic host_bit;
   // A line nobody drives is pulled up.
   assign sdio_in = !sdio_oe_n ? sdio_out : (host_oe ? host_bit : 1'b1);
   initial begin
      sclk_in = 1'b1;
      host_oe = 1'b1;
      host_bit = 1'b1;
   end
   task automatic half(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Read bits are taken late in the high phase, since the device answer trails the fall.
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      for (int i = 0; i < nbits; i++) begin
         sclk_in = 1'b0;
         host_oe = (i < 8) || word[15];
         host_bit = word[15 - i];
         half(4);
         sclk_in = 1'b1;
         half(3);
         rd = {rd[6:0], sdio_in};
         half(1);
      end
      half(4);
      host_bit = 1'b1;
      host_oe = 1'b1;
   endtask
endmodule

// [mhi_top_sva.sv]
`timescale 1ns/1ns
module mhi_top_sva (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sclk_in,
   input wire logic sdio_out,
   input wire logic sdio_oe_n,
   input wire logic x_phase_a,
   input wire logic x_phase_b,
   input wire logic y_phase_a,
   input wire logic y_phase_b,
   input wire logic power_save,
   input wire logic shutdown,
   input wire logic reg_write,
   input wire logic reg_read
);
   wire [1:0] xq;
   wire [1:0] yq;
   logic [3:0] hist;
   assign xq = {x_phase_a, x_phase_b};
   assign yq = {y_phase_a, y_phase_b};
   // Recent serial clock samples, to tie sdio moves to a nearby edge.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) hist <= 4'hf;
      else hist <= {hist[2:0], sclk_in};
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_reset_state: assert property ($rose(rst_n) |-> xq == 2'h0 && yq == 2'h0 && sdio_oe_n)
      else $error("state after reset wrong");
   chk_x_gray: assert property ($changed(xq) |-> $countones(xq ^ $past(xq)) == 1)
      else $error("x step not one phase");
   chk_y_gray: assert property ($changed(yq) |-> $countones(yq ^ $past(yq)) == 1)
      else $error("y step not one phase");
   chk_halt_hold: assert property (shutdown [*3] |=> $stable({xq, yq}))
      else $error("phases moved while halted");
   chk_idle_hold: assert property (power_save && $past(power_save) |-> $stable({xq, yq}))
      else $error("phases moved while idle");
   chk_write_no_drive: assert property (reg_write |-> sdio_oe_n)
      else $error("sdio driven at write");
   chk_abort_no_write: assert property (shutdown && $past(shutdown) |-> !reg_write)
      else $error("write during power down");
   chk_read_turn: assert property (reg_read |=> !reg_read ##0 sdio_oe_n [*3])
      else $error("read turnaround wrong");
   chk_move_on_fall: assert property ((!sdio_oe_n && $changed(sdio_out)) || $fell(sdio_oe_n)
      |-> hist != 4'hf)
      else $error("sdio moved away from a fall");
   chk_release_rise: assert property ($rose(sdio_oe_n) |-> hist != 4'h0)
      else $error("sdio released away from a rise");
   cover property (reg_write);
   cover property (reg_read);
   cover property ($rose(power_save));
   cover property ($fell(sdio_oe_n));
endmodule
bind mhi_top mhi_top_sva u_sva (.clock(clock), .rst_n(rst_n), .sclk_in(sclk_in),
   .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .x_phase_a(x_phase_a), .x_phase_b(x_phase_b),
   .y_phase_a(y_phase_a), .y_phase_b(y_phase_b), .power_save(power_save),
   .shutdown(shutdown), .reg_write(reg_write), .reg_read(reg_read));

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
   localparam int ST = mhi_pkg::STEP_CYCLES;
   localparam logic [1:0] GRAY [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   // Resync pulses keep the minimum width, so they dominate the run time.
   localparam int PD_HOLD = 700000 / mhi_pkg::CLK_PERIOD_NS;
   localparam int RUN_LIMIT = 2 * PD_HOLD + 20000;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic power_down_in = 1'b0;
   logic motion_valid = 1'b0;
   logic signed [7:0] delta_x = 8'sh00;
   logic signed [7:0] delta_y = 8'sh00;
   logic [7:0] reg_rdata = 8'h00;
   logic [7:0] rd;
   logic [7:0] wr_data;
   wire sclk_in, sdio_in, sdio_out, sdio_oe_n, x_phase_a, x_phase_b, y_phase_a, y_phase_b;
   wire power_save, shutdown, reg_write, reg_read;
   wire [6:0] reg_addr;
   wire [7:0] reg_wdata;
   wire [1:0] xq = {x_phase_a, x_phase_b};
   wire [1:0] yq = {y_phase_a, y_phase_b};
   int failures = 0;
   int n_checks = 0;
   int n_wr = 0;
   int n_rd = 0;
   always #25 clock = ~clock;
   mhi_top #(.IDLE_CYCLES(50), .WDOG_CYCLES(100)) u_dut (.clock(clock), .rst_n(rst_n),
      .power_down_in(power_down_in), .sclk_in(sclk_in), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .motion_valid(motion_valid),
      .delta_x(delta_x), .delta_y(delta_y), .x_phase_a(x_phase_a), .x_phase_b(x_phase_b),
      .y_phase_a(y_phase_a), .y_phase_b(y_phase_b), .power_save(power_save),
      .shutdown(shutdown), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   mhi_host_model u_host (.clock(clock), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
      .sclk_in(sclk_in), .sdio_in(sdio_in));
   always @(posedge clock) begin
      if (reg_write === 1'b1) begin
         n_wr <= n_wr + 1;
         wr_data <= reg_wdata;
      end
      if (reg_read === 1'b1) n_rd <= n_rd + 1;
   end
   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic pulse(input logic signed [7:0] dx, input logic signed [7:0] dy);
      motion_valid = 1'b1;
      delta_x = dx;
      delta_y = dy;
      cyc(1);
      motion_valid = 1'b0;
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic t_reset;
      compare({xq, yq, sdio_oe_n, power_save, shutdown}, 7'h04);
      $display("reset test done");
   endtask
   task automatic t_motion;
      pulse(8'sd3, -8'sd2);
      cyc(5 * ST);
      compare({xq, yq}, {GRAY[3], GRAY[2]});
      compare(power_save, 1'b1);
      cyc(3 * ST);
      compare({xq, yq}, {GRAY[3], GRAY[2]});
      pulse(8'sd1, 8'sd0);
      cyc(3);
      compare(power_save, 1'b0);
      cyc(2 * ST);
      compare(xq, GRAY[0]);
      $display("motion test done");
   endtask
   task automatic t_halt;
      power_down_in = 1'b1;
      cyc(10);
      compare(shutdown, 1'b1);
      pulse(8'sd2, 8'sd0);
      cyc(4 * ST);
      compare(xq, GRAY[0]);
      power_down_in = 1'b0;
      cyc(4 * ST);
      compare({shutdown, xq}, {1'b0, GRAY[2]});
      $display("halt test done");
   endtask
   task automatic t_write_read;
      int w0;
      int r0;
      w0 = n_wr;
      r0 = n_rd;
      reg_rdata = 8'h96;
      u_host.xfer({1'b1, 7'h2a, 8'hc5}, 16, rd);
      cyc(10);
      compare({reg_addr, wr_data}, {7'h2a, 8'hc5});
      compare(sdio_oe_n, 1'b1);
      u_host.xfer({1'b0, 7'h15, 8'h00}, 16, rd);
      cyc(10);
      compare({rd, 1'b0, reg_addr}, {8'h96, 8'h15});
      compare(n_wr - w0, 1);
      compare(n_rd - r0, 1);
      compare(sdio_oe_n, 1'b1);
      $display("write and read test done");
   endtask
   task automatic t_abort;
      int w0;
      w0 = n_wr;
      u_host.xfer({1'b1, 7'h2b, 8'hf0}, 12, rd);
      power_down_in = 1'b1;
      cyc(10);
      u_host.xfer(16'hffff, 4, rd);
      cyc(PD_HOLD);
      compare(n_wr - w0, 0);
      power_down_in = 1'b0;
      cyc(10);
      u_host.xfer({1'b0, 7'h15, 8'h00}, 12, rd);
      compare(sdio_oe_n, 1'b0);
      power_down_in = 1'b1;
      cyc(10);
      u_host.xfer(16'hffff, 1, rd);
      compare(sdio_oe_n, 1'b1);
      cyc(PD_HOLD);
      power_down_in = 1'b0;
      cyc(10);
      u_host.xfer({1'b1, 7'h33, 8'h5a}, 16, rd);
      cyc(10);
      compare({8'(n_wr - w0), wr_data}, {8'h01, 8'h5a});
      $display("abort test done");
   endtask
   task automatic t_wdog;
      int w0;
      w0 = n_wr;
      u_host.xfer({1'b1, 7'h40, 8'h77}, 5, rd);
      cyc(150);
      u_host.xfer({1'b1, 7'h11, 8'h3c}, 16, rd);
      cyc(10);
      compare({8'(n_wr - w0), 1'b0, reg_addr, wr_data}, {8'h01, 8'h11, 8'h3c});
      $display("watchdog test done");
   endtask
   initial begin
      cyc(16);
      rst_n = 1'b1;
      cyc(8);
      t_reset;
      t_motion;
      t_halt;
      t_write_read;
      t_abort;
      t_wdog;
      stop_test;
   end
   initial begin
      repeat (RUN_LIMIT) @(posedge clock);
      failures++;
      stop_test;
   end
endmodule
